// *** rtl/adl_pkg.sv ***
/*
 Constants, register map and field layouts for the converter output path.
 Assumes one device clock for every user and 32-bit AXI4-Lite data.
*/
package adl_pkg;
	// ------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------
	localparam int DW = 16;
	localparam int TAPS = 41;
	localparam int CENTER = 20;
	localparam int NCOEF = 10;
	localparam int CW = 18;
	localparam int AW = 40;
	localparam int COEF_SHIFT = 17;
	localparam logic signed [CW-1:0] COEF_CENTER = 18'h1_0000;
	// Odd-offset taps, outermost first; even offsets are zero
	localparam logic signed [CW-1:0] COEF [NCOEF] = '{
		18'h3_FF8A, 18'h0_013B, 18'h3_FD8A, 18'h0_046A, 18'h3_F8B2,
		18'h0_0B90, 18'h3_EE12, 18'h0_1CD4, 18'h3_CB9E, 18'h0_A281};
	localparam logic signed [DW-1:0] SMAX = 16'h7FFF;
	localparam logic signed [DW-1:0] SMIN = 16'h8000;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 100;
	localparam int FAST_OVERRANGE_FLAG_LAT_CYC = 18;
	localparam int FAST_OVERRANGE_FLAG_TPD_NS = 4;
	localparam int LMFC_W = 7;
	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_THRESH = 6'h01;
	localparam logic [5:0] IDX_SYSREF = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h04;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h05;
	localparam logic [5:0] IDX_KCFG = 6'h06;
	localparam int ST_CNT_POS = 8;
	localparam int IRQ_SYSREF = 0;
	localparam int IRQ_REALIGN = 1;
	localparam int IRQ_FAST_OVERRANGE_FLAG = 2;
	localparam logic [7:0] THRESH_RST = 8'hE3;
	localparam logic [4:0] K_RST = 5'h10;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// Control register layout
	// ------------------------------------------------------------
	typedef struct packed {
		logic sysref_mask;
		logic fast_overrange_flag_embed;
		logic four_lane;
		logic hp_sel;
		logic ddc_en;
	} adl_ctrl_t;
	localparam adl_ctrl_t CTRL_RST = 5'h00;
endpackage

// *** rtl/adl_top.sv ***
/*
 Dual-channel output path: half-band decimator, fast overrange flags,
 multiframe clock aligned by the reference pulse, AXI4-Lite registers.
 Assumes samples arrive one per clock on aclk; the reference pin is
 asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
module adl_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [15:0] adc_a,
	input wire logic signed [15:0] adc_b,
	input wire logic sysref,
	output logic signed [15:0] out_a,
	output logic signed [15:0] out_b,
	output logic out_valid,
	output logic lmfc_pulse,
	output logic four_lane,
	output logic fast_overrange_flag_a,
	output logic fast_overrange_flag_b,
	output logic sync_done,
	output logic irq
);
	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic signed [15:0] fir_out(
		input logic signed [15:0] t [adl_pkg::TAPS], input logic hp);
		logic signed [adl_pkg::AW-1:0] side;
		logic signed [adl_pkg::AW-1:0] ctr;
		logic signed [adl_pkg::AW-1:0] acc;
		side = '0;
		// Half-band: only odd offsets carry weight, paired by symmetry
		for (int k = 0; k < adl_pkg::NCOEF; k++)
			side = side + (adl_pkg::AW'(t[2*k+1]) + adl_pkg::AW'(t[adl_pkg::TAPS-2-2*k]))
				* adl_pkg::AW'(adl_pkg::COEF[k]);
		ctr = adl_pkg::AW'(t[adl_pkg::CENTER]) * adl_pkg::AW'(adl_pkg::COEF_CENTER);
		// High-pass mirrors the response by negating odd offsets
		acc = hp ? ctr - side : ctr + side;
		acc = acc >>> adl_pkg::COEF_SHIFT;
		if (acc > adl_pkg::AW'(adl_pkg::SMAX))
			return adl_pkg::SMAX;
		if (acc < adl_pkg::AW'(adl_pkg::SMIN))
			return adl_pkg::SMIN;
		return acc[15:0];
	endfunction

	function automatic logic ovr_hit(input logic signed [15:0] x, input logic [7:0] th);
		logic [16:0] mag;
		mag = x[15] ? 17'h0_0000 - {x[15], x} : {x[15], x};
		return mag[16:7] > {2'b00, th};
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a[7:2] <= adl_pkg::IDX_KCFG);
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	adl_pkg::adl_ctrl_t ctrl_r;
	logic [7:0] thresh_r;
	logic [4:0] k_r;
	logic [2:0] stat_r;
	logic [2:0] mask_r;
	logic man_pulse_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic sr_meta_r, sr_sync_r, sr_last_r;
	logic seen_r;
	logic [adl_pkg::LMFC_W-1:0] cnt_r;
	logic lmfc_r;
	logic phase_r;
	logic signed [15:0] tap_r [2][adl_pkg::TAPS];
	logic signed [15:0] out_r [2];
	logic out_valid_r;
	logic [adl_pkg::FAST_OVERRANGE_FLAG_LAT_CYC-2:0] dly_r [2];
	logic [1:0] fast_overrange_flag_r;
	logic irq_r;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic wr_fire, wr_ok, wr_sel;
	logic [5:0] wr_idx, rd_idx;
	logic [31:0] rd_data;
	assign wr_fire = !awready_r && !wready_r && !bvalid_r;
	assign wr_ok = addr_ok(awaddr_r);
	assign wr_sel = wr_fire && wr_ok && wstrb0_r;
	assign wr_idx = awaddr_r[7:2];
	assign rd_idx = s_axi_araddr[7:2];
	assign rd_data =
		(rd_idx == adl_pkg::IDX_CTRL) ? 32'(ctrl_r) :
		(rd_idx == adl_pkg::IDX_THRESH) ? 32'(thresh_r) :
		(rd_idx == adl_pkg::IDX_STATUS) ?
			32'({cnt_r, {(adl_pkg::ST_CNT_POS-1){1'b0}}, seen_r}) :
		(rd_idx == adl_pkg::IDX_IRQ_STAT) ? 32'(stat_r) :
		(rd_idx == adl_pkg::IDX_IRQ_MASK) ? 32'(mask_r) :
		(rd_idx == adl_pkg::IDX_KCFG) ? 32'(k_r) : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= adl_pkg::RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb0_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				awaddr_r <= s_axi_awaddr;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid && wready_r) begin
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
				wready_r <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? adl_pkg::RESP_OKAY : adl_pkg::RESP_SLVERR;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= adl_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= addr_ok(s_axi_araddr) ? rd_data : 32'h0000_0000;
			rresp_r <= addr_ok(s_axi_araddr) ? adl_pkg::RESP_OKAY : adl_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= adl_pkg::CTRL_RST;
			thresh_r <= adl_pkg::THRESH_RST;
			k_r <= adl_pkg::K_RST;
			mask_r <= adl_pkg::MASK_RST;
			man_pulse_r <= 1'b0;
		end else begin
			if (wr_sel && wr_idx == adl_pkg::IDX_CTRL)
				ctrl_r <= wdata_r[4:0];
			if (wr_sel && wr_idx == adl_pkg::IDX_THRESH)
				thresh_r <= wdata_r[7:0];
			if (wr_sel && wr_idx == adl_pkg::IDX_KCFG)
				k_r <= wdata_r[4:0];
			if (wr_sel && wr_idx == adl_pkg::IDX_IRQ_MASK)
				mask_r <= wdata_r[2:0];
			// Register-made reference pulse for setups without the pin
			man_pulse_r <= wr_sel && wr_idx == adl_pkg::IDX_SYSREF && wdata_r[0];
		end
	end

	// ------------------------------------------------------------
	// Reference capture and multiframe clock
	// ------------------------------------------------------------
	logic sr_rise, sysref_hit, realign;
	logic [4:0] k_eff;
	logic [adl_pkg::LMFC_W-1:0] lmfc_last, cnt_nxt;
	// Only the second stage feeds the edge detector
	assign sr_rise = sr_sync_r && !sr_last_r && !ctrl_r.sysref_mask;
	assign sysref_hit = sr_rise || man_pulse_r;
	assign k_eff = (k_r == 5'h00) ? 5'h01 : k_r;
	// Bypass period is half the decimated one, since frames hold raw samples
	assign lmfc_last = ctrl_r.ddc_en ? {k_eff, 2'b00} - 7'h01
		: {1'b0, k_eff, 1'b0} - 7'h01;
	// A pulse in phase lands on the wrap and changes nothing
	assign cnt_nxt = (sysref_hit || cnt_r >= lmfc_last) ? '0 : cnt_r + 7'h01;
	assign realign = sysref_hit && cnt_r != lmfc_last;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sr_meta_r <= 1'b0;
			sr_sync_r <= 1'b0;
			sr_last_r <= 1'b0;
			seen_r <= 1'b0;
			cnt_r <= '0;
			lmfc_r <= 1'b0;
		end else begin
			sr_meta_r <= sysref;
			sr_sync_r <= sr_meta_r;
			sr_last_r <= sr_sync_r;
			seen_r <= seen_r || sysref_hit;
			cnt_r <= cnt_nxt;
			lmfc_r <= cnt_nxt == '0;
		end
	end

	// ------------------------------------------------------------
	// Filter and output stage
	// ------------------------------------------------------------
	logic signed [15:0] adc_in [2];
	logic signed [15:0] smp_nxt [2];
	logic [1:0] fast_overrange_flag_nxt;
	assign adc_in[0] = adc_a;
	assign adc_in[1] = adc_b;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic signed [15:0] pick;
		assign pick = ctrl_r.ddc_en ? fir_out(tap_r[c], ctrl_r.hp_sel) : adc_in[c];
		assign smp_nxt[c] = ctrl_r.fast_overrange_flag_embed ? {pick[15:1], fast_overrange_flag_r[c]} : pick;
		assign fast_overrange_flag_nxt[c] = dly_r[c][adl_pkg::FAST_OVERRANGE_FLAG_LAT_CYC-2];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int c = 0; c < 2; c++)
				for (int n = 0; n < adl_pkg::TAPS; n++)
					tap_r[c][n] <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				tap_r[c][0] <= adc_in[c];
				for (int n = 1; n < adl_pkg::TAPS; n++)
					tap_r[c][n] <= tap_r[c][n-1];
			end
		end
	end

	// Decimation phase restarts with the frame so output slots are deterministic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_r <= 1'b0;
			out_r[0] <= '0;
			out_r[1] <= '0;
			out_valid_r <= 1'b0;
		end else begin
			phase_r <= ctrl_r.ddc_en && !sysref_hit && !phase_r;
			out_r[0] <= smp_nxt[0];
			out_r[1] <= smp_nxt[1];
			out_valid_r <= seen_r && (!ctrl_r.ddc_en || phase_r);
		end
	end

	// ------------------------------------------------------------
	// Fast overrange
	// ------------------------------------------------------------
	// Pin gate delay is a few ns, well under one clock, so it adds no stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_r[0] <= '0;
			dly_r[1] <= '0;
			fast_overrange_flag_r <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++)
				dly_r[c] <= {dly_r[c][adl_pkg::FAST_OVERRANGE_FLAG_LAT_CYC-3:0], ovr_hit(adc_in[c], thresh_r)};
			fast_overrange_flag_r <= fast_overrange_flag_nxt;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [2:0] stat_ev, stat_clr, stat_nxt;
	assign stat_ev = {|(fast_overrange_flag_nxt & ~fast_overrange_flag_r), realign, sysref_hit};
	assign stat_clr = (wr_sel && wr_idx == adl_pkg::IDX_IRQ_STAT) ? wdata_r[2:0] : 3'h0;
	// Set beats clear in the same cycle
	assign stat_nxt = (stat_r & ~stat_clr) | stat_ev;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq_r <= |(stat_nxt & mask_r);
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign out_a = out_r[0];
	assign out_b = out_r[1];
	assign out_valid = out_valid_r;
	assign lmfc_pulse = lmfc_r;
	assign four_lane = ctrl_r.four_lane;
	assign fast_overrange_flag_a = fast_overrange_flag_r[0];
	assign fast_overrange_flag_b = fast_overrange_flag_r[1];
	assign sync_done = seen_r;
	assign irq = irq_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic [4:0] up_r;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			up_r <= '0;
		else if (up_r != 5'h1F)
			up_r <= up_r + 5'h01;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_fast_overrange_flag_lat;
		up_r > 5'h13 |-> fast_overrange_flag_a == $past(ovr_hit(adc_a, thresh_r), 18);
	endproperty
	a_fast_overrange_flag_lat: assert property (p_fast_overrange_flag_lat) else $error("fast_overrange_flag latency wrong");

	property p_bypass;
		!ctrl_r.ddc_en && seen_r && $stable(ctrl_r) |=> out_valid && out_a[15:1] == $past(adc_a[15:1]);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass path wrong");

	property p_decim;
		ctrl_r.ddc_en && out_valid && !sysref_hit ##1 ctrl_r.ddc_en |-> !out_valid;
	endproperty
	a_decim: assert property (p_decim) else $error("decimation rate wrong");

	property p_sysref_zero;
		sysref_hit |=> cnt_r == '0 ##0 lmfc_pulse;
	endproperty
	a_sysref_zero: assert property (p_sysref_zero) else $error("lmfc not reset");

	property p_lmfc_step;
		!sysref_hit && cnt_r < lmfc_last |=> cnt_r == $past(cnt_r) + 7'h01;
	endproperty
	a_lmfc_step: assert property (p_lmfc_step) else $error("lmfc count wrong");

	property p_kcfg;
		wr_sel && wr_idx == adl_pkg::IDX_KCFG |=> k_r == $past(wdata_r[4:0]);
	endproperty
	a_kcfg: assert property (p_kcfg) else $error("K write lost");

	property p_gate;
		!sync_done |-> !out_valid;
	endproperty
	a_gate: assert property (p_gate) else $error("data before sync");

	property p_embed;
		out_valid && $past(ctrl_r.fast_overrange_flag_embed) |-> out_a[0] == $past(fast_overrange_flag_a);
	endproperty
	a_embed: assert property (p_embed) else $error("flag not embedded");

	property p_capture;
		sr_sync_r && !sr_last_r && !ctrl_r.sysref_mask |=> sync_done ##0 stat_r[0];
	endproperty
	a_capture: assert property (p_capture) else $error("sysref not captured");
endmodule // adl_top

// *** tb/adl_ref_src.sv ***
/*
 Reference pulse source at the far side of the output path.
 Assumes it shares aclk with the device; pulses last one cycle.
*/
`timescale 1ns/1ps
module adl_ref_src (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire logic [7:0] period,
	output logic sysref
);
	// ------------------------------------------------------------
	// Periodic pulse
	// ------------------------------------------------------------
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	// Period must be the multiframe length times a power of two
	assign cnt_nxt = (cnt_r == period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
	// Stopping and restarting shifts the phase; used to force realign
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			cnt_r <= 8'h00;
			sysref <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			sysref <= (cnt_r == 8'h00);
		end
	end
endmodule // adl_ref_src

// *** tb/tb.sv ***
/*
 Self-checking bench for the converter output path.
 Assumes registered AXI4-Lite answers and a 10 MHz device clock.
*/
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic [1:0] rs;} adl_row_t;
	logic aclk;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic signed [15:0] adc_a = 16'h0000;
	logic signed [15:0] adc_b = 16'h0000;
	logic ref_en = 1'b0;
	logic sysref;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic signed [15:0] out_a, out_b;
	logic out_valid, lmfc_pulse, four_lane, fast_overrange_flag_a, fast_overrange_flag_b, sync_done, irq;
	int n_mismatch = 0;
	int num_checks = 0;
	int n;
	logic [31:0] rd;
	logic [1:0] rs;
	adl_row_t rows [12] = '{
		'{8'h00, 1'b0, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{8'h04, 1'b0, 32'h0000_0000, 32'h0000_00E3, 2'h0},
		'{8'h18, 1'b0, 32'h0000_0000, 32'h0000_0010, 2'h0},
		'{8'h14, 1'b0, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{8'h10, 1'b0, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{8'h08, 1'b0, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{8'h3C, 1'b0, 32'h0000_0000, 32'h0000_0000, 2'h2},
		'{8'h04, 1'b1, 32'hFFFF_FF5A, 32'h0000_0000, 2'h0},
		'{8'h04, 1'b0, 32'h0000_0000, 32'h0000_005A, 2'h0},
		'{8'h18, 1'b1, 32'hFFFF_FFE2, 32'h0000_0000, 2'h0},
		'{8'h18, 1'b0, 32'h0000_0000, 32'h0000_0002, 2'h0},
		'{8'h3C, 1'b1, 32'h0000_0001, 32'h0000_0000, 2'h2}};

	adl_top adl_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(rready), .adc_a(adc_a), .adc_b(adc_b), .sysref(sysref),
		.out_a(out_a), .out_b(out_b), .out_valid(out_valid), .lmfc_pulse(lmfc_pulse),
		.four_lane(four_lane), .fast_overrange_flag_a(fast_overrange_flag_a), .fast_overrange_flag_b(fast_overrange_flag_b), .sync_done(sync_done),
		.irq(irq));
	adl_ref_src adl_ref_src_i (.aclk(aclk), .aresetn(aresetn), .en(ref_en),
		.period(8'h08), .sysref(sysref));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Ready flags are read mid-cycle, where registered outputs are settled
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		logic ha, hw, dn;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		t = 0;
		do begin
			@(negedge aclk);
			ha = awvalid && s_axi_awready === 1'b1;
			hw = wvalid && s_axi_wready === 1'b1;
			dn = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			t++;
		end while (!dn && t < 50);
		bready <= 1'b0;
		if (!dn) n_mismatch++;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		logic ha, dn;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		do begin
			@(negedge aclk);
			ha = arvalid && s_axi_arready === 1'b1;
			dn = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			t++;
		end while (!dn && t < 50);
		rready <= 1'b0;
		if (!dn) n_mismatch++;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge aclk);
		@(negedge aclk);
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// About 500 cycles are needed; twenty thousand leaves wide margin
	initial begin
		#(20000 * 100);
		n_mismatch++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		adc_a <= 16'h1234;
		adc_b <= 16'h0F0E;
		settle(0);
		chkb(s_axi_awready, 1'b1);
		chkb(irq, 1'b0);
		chkb(four_lane, 1'b0);
		foreach (rows[i]) begin
			if (rows[i].w) begin
				axi_wr(rows[i].a, rows[i].d, rs);
			end else begin
				axi_rd(rows[i].a, rd, rs);
				chk(rd, rows[i].e);
			end
			chk({30'h0000_0000, rs}, {30'h0000_0000, rows[i].rs});
		end
		chkb(out_valid, 1'b0);
		chkb(sync_done, 1'b0);
		axi_wr(8'h08, 32'h0000_0001, rs);
		n = 0;
		do settle(0); while (sync_done !== 1'b1 && ++n < 10);
		chkb(sync_done, 1'b1);
		axi_rd(8'h10, rd, rs);
		// Realign bit depends on counter phase at the write, so only bits 0 and 2
		chk(rd & 32'h0000_0005, 32'h0000_0001);
		axi_wr(8'h10, 32'h0000_0001, rs);
		settle(1);
		chk({16'h0000, out_a}, 32'h0000_1234);
		chk({16'h0000, out_b}, 32'h0000_0F0E);
		chkb(out_valid, 1'b1);
		@(posedge aclk);
		adc_a <= 16'h7FFE;
		adc_b <= 16'h8001;
		@(posedge aclk);
		adc_a <= 16'h0000;
		adc_b <= 16'h0F0E;
		settle(16);
		chkb(fast_overrange_flag_a, 1'b0);
		chkb(fast_overrange_flag_b, 1'b0);
		settle(1);
		chkb(fast_overrange_flag_a, 1'b1);
		chkb(fast_overrange_flag_b, 1'b1);
		settle(1);
		chkb(fast_overrange_flag_b, 1'b0);
		axi_wr(8'h14, 32'h0000_0004, rs);
		settle(2);
		chkb(irq, 1'b1);
		axi_wr(8'h10, 32'h0000_0004, rs);
		settle(2);
		chkb(irq, 1'b0);
		axi_wr(8'h00, 32'h0000_0008, rs);
		adc_a <= 16'h7FFE;
		settle(25);
		chk({16'h0000, out_a}, 32'h0000_7FFF);
		adc_a <= 16'h0103;
		settle(25);
		chk({16'h0000, out_a}, 32'h0000_0102);
		axi_wr(8'h00, 32'h0000_0004, rs);
		settle(2);
		chkb(four_lane, 1'b1);
		// Lane choice must not leak into the data path
		chk({16'h0000, out_a}, 32'h0000_0103);
		axi_wr(8'h00, 32'h0000_0001, rs);
		adc_a <= 16'h4000;
		adc_b <= 16'h4000;
		settle(60);
		n = 0;
		repeat (20) begin
			if (out_valid === 1'b1) n++;
			settle(1);
		end
		chk(n, 10);
		chk({16'h0000, out_a}, 32'h0000_4000);
		axi_wr(8'h00, 32'h0000_0003, rs);
		settle(60);
		chk({16'h0000, out_b}, 32'h0000_0000);
		adc_a <= 16'h0000;
		adc_b <= 16'h0000;
		axi_wr(8'h00, 32'h0000_0001, rs);
		ref_en <= 1'b1;
		settle(40);
		n = 0;
		do settle(0); while (lmfc_pulse !== 1'b1 && ++n < 40);
		n = 0;
		do begin
			settle(0);
			n++;
		end while (lmfc_pulse !== 1'b1 && n < 40);
		chk(n, 8);
		n = 0;
		do settle(0); while (sysref !== 1'b1 && ++n < 40);
		n = 0;
		do begin
			settle(0);
			n++;
		end while (lmfc_pulse !== 1'b1 && n < 40);
		chk(n, 3);
		axi_wr(8'h10, 32'h0000_0007, rs);
		settle(30);
		axi_rd(8'h10, rd, rs);
		chk(rd, 32'h0000_0001);
		n = 0;
		do settle(0); while (sysref !== 1'b1 && ++n < 40);
		@(posedge aclk);
		ref_en <= 1'b0;
		repeat (3) @(posedge aclk);
		ref_en <= 1'b1;
		settle(20);
		axi_rd(8'h10, rd, rs);
		chk(rd, 32'h0000_0003);
		stop_test();
	end
endmodule // tb
